// *** flpn_std_end.sv ***
// Summary of operation
// - One version across all three layers
// - Frames carry revision, marker, checksum preference
// - Reply revision may differ from request
// - Set version and per-direction marker state
// - Same version both directions and layers
// - Legacy peer forces checksum both ways
// - Non-permissive keeps standard version always
// - Each receive direction uses receiver's marker
// - Legacy initiator requests revision zero, M, C
// - Non-permissive responder replies one, then closes
// - Non-permissive initiator requests revision one
// - Legacy responder replies revision zero, M set
// - Non-permissive initiator closes on legacy reply
// - Permissive adapter picks version per connection
// - Legacy exchange done before RDMA conversion
// - Permissive responder never replies to legacy with M clear
// - Permissive responder mirrors legacy, flags upper layer
// - Permissive initiator adapts to legacy reply
`timescale 1ns/1ps
module flpn_std_end (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    flpn_link_if.std_end link,
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output logic rdma_mode_out,
    output logic closed_out,
    output logic ver_out,
    output logic mrk_init_rx_out,
    output logic mrk_resp_rx_out,
    output logic crc_en_out,
    output logic ulp_legacy_out
);

    // ********************************************************
    // Control register
    // ********************************************************
    logic permissive;     // May fall back to legacy protocols
    logic pref_m;         // Own marker preference
    logic pref_c;         // Own checksum preference

    // Write decode for the control word
    wire ctrl_wr = reg_wr_in && (reg_addr_in == flpn_pkg::OFS_CTRL);

    // Stored control fields
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            permissive <= flpn_pkg::RST_PERMISSIVE;
            pref_m <= flpn_pkg::RST_PREF_M;
            pref_c <= flpn_pkg::RST_PREF_C;
        end else if (ctrl_wr) begin
            permissive <= reg_wdata_in[flpn_pkg::CTRL_PERMISSIVE_BIT];
            pref_m <= reg_wdata_in[flpn_pkg::CTRL_PREF_M_BIT];
            pref_c <= reg_wdata_in[flpn_pkg::CTRL_PREF_C_BIT];
        end
    end

    // Self-clearing command bits, never stored
    wire start_pls = ctrl_wr && reg_wdata_in[flpn_pkg::CTRL_START_BIT]; // One-cycle order to initiate
    wire restart_pls = ctrl_wr && reg_wdata_in[flpn_pkg::CTRL_RESTART_BIT]; // One-cycle order to drop the link

    // ********************************************************
    // Negotiation state
    // ********************************************************
    flpn_pkg::flpn_state_t state;
    logic neg_ver;        // Resolved version, held until switch
    logic neg_m_init;     // Initiator receive markers
    logic neg_m_resp;     // Responder receive markers
    logic neg_crc;        // Checksum in use
    logic neg_legacy;     // Upper layer must emit legacy headers

    // Incoming frames split by kind
    wire rx_req = link.leg_frm_vld && !link.leg_frm_rep;
    wire rx_rep = link.leg_frm_vld && link.leg_frm_rep;
    // Deciding frame for this connection, and the permissive legacy fallback
    wire decide = !link.leg_close && ((state == flpn_pkg::ST_IDLE && rx_req) ||
        (state == flpn_pkg::ST_WAIT_REP && rx_rep));
    wire fallback = permissive && (link.leg_frm_rev == flpn_pkg::REV_LEGACY);

    // Main sequencer; a peer close wins over all other events except a restart
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            state <= flpn_pkg::ST_IDLE;
        end else if (restart_pls) begin
            state <= flpn_pkg::ST_IDLE;
        end else begin
            case (state)
                flpn_pkg::ST_IDLE: begin
                    if (link.leg_close) begin
                        state <= flpn_pkg::ST_CLOSED;
                    end else if (rx_req && link.leg_frm_rev == flpn_pkg::REV_LEGACY && !permissive) begin
                        state <= flpn_pkg::ST_CLOSING;
                    end else if (rx_req) begin
                        state <= flpn_pkg::ST_RDMA;
                    end else if (start_pls) begin
                        state <= flpn_pkg::ST_WAIT_REP;
                    end
                end
                flpn_pkg::ST_WAIT_REP: begin
                    if (link.leg_close) begin
                        state <= flpn_pkg::ST_CLOSED;
                    end else if (rx_rep && link.leg_frm_rev == flpn_pkg::REV_LEGACY && !permissive) begin
                        state <= flpn_pkg::ST_CLOSING;
                    end else if (rx_rep) begin
                        state <= flpn_pkg::ST_RDMA;
                    end
                end
                flpn_pkg::ST_RDMA: begin
                    if (link.leg_close) begin
                        state <= flpn_pkg::ST_CLOSED;
                    end
                end
                // Close signalled once, then parked until restart
                flpn_pkg::ST_CLOSING, flpn_pkg::ST_CLOSED: begin
                    state <= flpn_pkg::ST_CLOSED;
                end
                default: begin
                    state <= flpn_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ********************************************************
    // Outgoing frames
    // ********************************************************
    // Registered one-cycle frame and close pulses
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            link.std_frm_vld <= 1'b0;
            link.std_frm_rep <= 1'b0;
            link.std_frm_rev <= flpn_pkg::REV_STD;
            link.std_frm_m <= 1'b0;
            link.std_frm_c <= 1'b0;
            link.std_close <= 1'b0;
        end else begin
            link.std_frm_vld <= 1'b0;
            link.std_close <= (state == flpn_pkg::ST_CLOSING);
            if (state == flpn_pkg::ST_IDLE && !restart_pls && !link.leg_close) begin
                if (rx_req) begin
                    link.std_frm_vld <= 1'b1;
                    link.std_frm_rep <= 1'b1;
                    if (link.leg_frm_rev == flpn_pkg::REV_LEGACY && permissive) begin
                        link.std_frm_rev <= flpn_pkg::REV_LEGACY;
                        link.std_frm_m <= flpn_pkg::PREF_ON;
                        link.std_frm_c <= flpn_pkg::PREF_ON;
                    end else begin
                        link.std_frm_rev <= flpn_pkg::REV_STD;
                        link.std_frm_m <= pref_m;
                        link.std_frm_c <= pref_c;
                    end
                end else if (start_pls) begin
                    link.std_frm_vld <= 1'b1;
                    link.std_frm_rep <= 1'b0;
                    link.std_frm_rev <= flpn_pkg::REV_STD;
                    link.std_frm_m <= reg_wdata_in[flpn_pkg::CTRL_PREF_M_BIT]; // Offer from the starting write
                    link.std_frm_c <= reg_wdata_in[flpn_pkg::CTRL_PREF_C_BIT];
                end
            end
        end
    end

    // ********************************************************
    // Parameter resolution
    // ********************************************************
    // Own offer is read back from the control word: rewriting it mid-exchange alters the result
    always_ff @(posedge clk_sys_in) begin
        if (srst_in || restart_pls) begin
            neg_ver <= flpn_pkg::VER_STD;
            neg_m_init <= 1'b0;
            neg_m_resp <= 1'b0;
            neg_crc <= 1'b0;
            neg_legacy <= 1'b0;
        end else if (decide && fallback) begin
            neg_ver <= flpn_pkg::VER_LEGACY;
            neg_m_init <= flpn_pkg::PREF_ON;
            neg_m_resp <= flpn_pkg::PREF_ON;
            neg_crc <= flpn_pkg::PREF_ON;
            neg_legacy <= 1'b1;
        end else if (decide) begin
            neg_ver <= flpn_pkg::VER_STD;
            neg_m_init <= (state == flpn_pkg::ST_IDLE) ? link.leg_frm_m : pref_m;
            neg_m_resp <= (state == flpn_pkg::ST_IDLE) ? pref_m : link.leg_frm_m;
            neg_crc <= link.leg_frm_c | pref_c;
            neg_legacy <= 1'b0;
        end
    end

    // ********************************************************
    // Results toward the framing datapath
    // ********************************************************
    // Held back until the switch so framing never sees half a result
    always_ff @(posedge clk_sys_in) begin
        if (srst_in || restart_pls) begin
            rdma_mode_out <= 1'b0;
            ver_out <= flpn_pkg::VER_STD;
            mrk_init_rx_out <= 1'b0;
            mrk_resp_rx_out <= 1'b0;
            crc_en_out <= 1'b0;
            ulp_legacy_out <= 1'b0;
        end else if (state == flpn_pkg::ST_RDMA && !rdma_mode_out) begin
            rdma_mode_out <= 1'b1;
            ver_out <= neg_ver;
            mrk_init_rx_out <= neg_m_init;
            mrk_resp_rx_out <= neg_m_resp;
            crc_en_out <= neg_crc;
            ulp_legacy_out <= neg_legacy;
        end else if (state != flpn_pkg::ST_RDMA) begin
            rdma_mode_out <= 1'b0;
        end
    end

    // Closed flag follows the state
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            closed_out <= 1'b0;
        end else begin
            closed_out <= (state == flpn_pkg::ST_CLOSED) && !restart_pls;
        end
    end

    // ********************************************************
    // Register read port
    // ********************************************************
    // Read data valid the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            reg_rdata_out <= 32'h0;
        end else if (reg_rd_in) begin
            reg_rdata_out <= 32'h0;
            if (reg_addr_in == flpn_pkg::OFS_CTRL) begin
                reg_rdata_out[flpn_pkg::CTRL_PERMISSIVE_BIT] <= permissive;
                reg_rdata_out[flpn_pkg::CTRL_PREF_M_BIT] <= pref_m;
                reg_rdata_out[flpn_pkg::CTRL_PREF_C_BIT] <= pref_c;
            end else if (reg_addr_in == flpn_pkg::OFS_STATUS) begin
                reg_rdata_out[flpn_pkg::STAT_STATE_LSB +: 3] <= state;
                reg_rdata_out[flpn_pkg::STAT_RDMA_BIT] <= rdma_mode_out;
                reg_rdata_out[flpn_pkg::STAT_CLOSED_BIT] <= closed_out;
                reg_rdata_out[flpn_pkg::STAT_VER_BIT] <= ver_out;
                reg_rdata_out[flpn_pkg::STAT_M_INIT_BIT] <= mrk_init_rx_out;
                reg_rdata_out[flpn_pkg::STAT_M_RESP_BIT] <= mrk_resp_rx_out;
                reg_rdata_out[flpn_pkg::STAT_CRC_BIT] <= crc_en_out;
                reg_rdata_out[flpn_pkg::STAT_LEGACY_BIT] <= ulp_legacy_out;
            end
        end
    end

endmodule

// *** flpn_pkg.sv ***
// ********************************************************
// Shared constants for the link parameter negotiator
// ********************************************************
package flpn_pkg;

    // ********************************************************
    // Wire encodings
    // ********************************************************
    // Revision carried in request and reply frames
    localparam logic REV_LEGACY = 1'b0;
    localparam logic REV_STD = 1'b1;
    // Upper protocol version field
    localparam logic VER_LEGACY = 1'b0;
    localparam logic VER_STD = 1'b1;
    // Marker and checksum preference
    localparam logic PREF_OFF = 1'b0;
    localparam logic PREF_ON = 1'b1;

    // ********************************************************
    // Register map, word aligned byte offsets
    // ********************************************************
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    // Control fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_PERMISSIVE_BIT = 1;
    localparam int CTRL_PREF_M_BIT = 2;
    localparam int CTRL_PREF_C_BIT = 3;
    localparam int CTRL_RESTART_BIT = 4;
    // Status fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_RDMA_BIT = 4;
    localparam int STAT_CLOSED_BIT = 5;
    localparam int STAT_VER_BIT = 6;
    localparam int STAT_M_INIT_BIT = 7;
    localparam int STAT_M_RESP_BIT = 8;
    localparam int STAT_CRC_BIT = 9;
    localparam int STAT_LEGACY_BIT = 10;
    // Reset values of control fields
    localparam logic RST_PERMISSIVE = 1'b1;
    localparam logic RST_PREF_M = 1'b0;
    localparam logic RST_PREF_C = 1'b1;

    // ********************************************************
    // Negotiation states, Gray coded along the usual path
    // ********************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT_REP = 3'b001,
        ST_RDMA = 3'b011,
        ST_CLOSING = 3'b111,
        ST_CLOSED = 3'b110
    } flpn_state_t;

endpackage

// *** flpn_link_if.sv ***
`timescale 1ns/1ps
// ********************************************************
// Streaming-mode exchange between the two adapters
// ********************************************************
interface flpn_link_if;
    // Frame sent by the standard end
    logic std_frm_vld;
    logic std_frm_rep;
    logic std_frm_rev;
    logic std_frm_m;
    logic std_frm_c;
    logic std_close;
    // Frame sent by the legacy peer
    logic leg_frm_vld;
    logic leg_frm_rep;
    logic leg_frm_rev;
    logic leg_frm_m;
    logic leg_frm_c;
    logic leg_close;

    // Standard adapter end
    modport std_end (
        output std_frm_vld, std_frm_rep, std_frm_rev, std_frm_m, std_frm_c, std_close,
        input leg_frm_vld, leg_frm_rep, leg_frm_rev, leg_frm_m, leg_frm_c, leg_close
    );
    // Legacy peer end
    modport leg_end (
        input std_frm_vld, std_frm_rep, std_frm_rev, std_frm_m, std_frm_c, std_close,
        output leg_frm_vld, leg_frm_rep, leg_frm_rev, leg_frm_m, leg_frm_c, leg_close
    );
endinterface

// *** flpn_leg_end.sv ***
`timescale 1ns/1ps
// ********************************************************
// Legacy-variant peer: fixed legacy offer, no fallback
// ********************************************************
module flpn_leg_end (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    flpn_link_if.leg_end link,
    input wire logic start_in,
    output logic rdma_mode_out,
    output logic closed_out
);

    // Connection progress, same state set as the standard end
    flpn_pkg::flpn_state_t state;

    // Incoming frames split by kind
    wire rx_req = link.std_frm_vld && !link.std_frm_rep;
    wire rx_rep = link.std_frm_vld && link.std_frm_rep;

    // ********************************************************
    // Sequencer
    // ********************************************************
    // exchange before conversion
    // Any request, or a legacy reply to its own request, lets this end reach RDMA mode; it cannot run the standard version
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            state <= flpn_pkg::ST_IDLE;
        end else begin
            case (state)
                flpn_pkg::ST_IDLE: begin
                    if (link.std_close) begin
                        state <= flpn_pkg::ST_CLOSED;
                    end else if (rx_req) begin
                        state <= flpn_pkg::ST_RDMA;
                    end else if (start_in) begin
                        state <= flpn_pkg::ST_WAIT_REP;
                    end
                end
                flpn_pkg::ST_WAIT_REP: begin
                    if (link.std_close) begin
                        state <= flpn_pkg::ST_CLOSED;
                    end else if (rx_rep && link.std_frm_rev == flpn_pkg::REV_LEGACY) begin
                        state <= flpn_pkg::ST_RDMA;
                    end else if (rx_rep) begin
                        // Standard-only peer, so give the connection up
                        state <= flpn_pkg::ST_CLOSING;
                    end
                end
                flpn_pkg::ST_RDMA: begin
                    if (link.std_close) begin
                        state <= flpn_pkg::ST_CLOSED;
                    end
                end
                // Close signalled once, then parked until reset
                flpn_pkg::ST_CLOSING, flpn_pkg::ST_CLOSED: begin
                    state <= flpn_pkg::ST_CLOSED;
                end
                default: begin
                    state <= flpn_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ********************************************************
    // Outgoing frames
    // ********************************************************
    // Fixed legacy offer: revision zero, markers and checksum always on
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            link.leg_frm_vld <= 1'b0;
            link.leg_frm_rep <= 1'b0;
            link.leg_frm_rev <= flpn_pkg::REV_LEGACY;
            link.leg_frm_m <= flpn_pkg::PREF_ON;
            link.leg_frm_c <= flpn_pkg::PREF_ON;
            link.leg_close <= 1'b0;
        end else begin
            link.leg_frm_vld <= 1'b0;
            link.leg_close <= (state == flpn_pkg::ST_CLOSING);
            if (state == flpn_pkg::ST_IDLE && !link.std_close) begin
                if (rx_req) begin
                    link.leg_frm_vld <= 1'b1;
                    link.leg_frm_rep <= 1'b1;
                    link.leg_frm_rev <= flpn_pkg::REV_LEGACY;
                    link.leg_frm_m <= flpn_pkg::PREF_ON;
                end else if (start_in) begin
                    link.leg_frm_vld <= 1'b1;
                    link.leg_frm_rep <= 1'b0;
                    link.leg_frm_rev <= flpn_pkg::REV_LEGACY;
                    link.leg_frm_m <= flpn_pkg::PREF_ON;
                    link.leg_frm_c <= flpn_pkg::PREF_ON;
                end
            end
        end
    end

    // Mode and close flags follow the state
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            rdma_mode_out <= 1'b0;
            closed_out <= 1'b0;
        end else begin
            rdma_mode_out <= (state == flpn_pkg::ST_RDMA);
            closed_out <= (state == flpn_pkg::ST_CLOSED);
        end
    end

endmodule

// *** flpn_link_checker.sv ***
`timescale 1ns/1ps
// ********************************************************
// Wire checks on the link between the two adapter ends
// ********************************************************
module flpn_link_checker (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic std_frm_vld,
    input wire logic std_frm_rep,
    input wire logic std_frm_rev,
    input wire logic std_frm_m,
    input wire logic std_frm_c,
    input wire logic std_close,
    input wire logic leg_frm_vld,
    input wire logic leg_frm_rep,
    input wire logic leg_frm_rev,
    input wire logic leg_frm_m,
    input wire logic leg_frm_c,
    input wire logic leg_close
);
    // One clock domain, so one default clock and reset
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);

    a_leg_req_fields: assert property (
        leg_frm_vld && !leg_frm_rep |-> !leg_frm_rev && leg_frm_m && leg_frm_c)
        else $error("legacy request fields wrong");
    a_leg_rep_fields: assert property (
        leg_frm_vld && leg_frm_rep |-> !leg_frm_rev && leg_frm_m)
        else $error("legacy reply fields wrong");
    a_std_req_rev: assert property (
        std_frm_vld && !std_frm_rep |-> std_frm_rev)
        else $error("standard request revision wrong");
    a_std_rep_marker: assert property (
        std_frm_vld && std_frm_rep && !std_frm_rev |-> std_frm_m)
        else $error("legacy style reply has marker clear");
    a_std_rep_crc: assert property (
        std_frm_vld && std_frm_rep && !std_frm_rev |-> std_frm_c)
        else $error("legacy style reply has checksum clear");
    a_nonperm_rep_close: assert property (
        std_frm_vld && std_frm_rep && std_frm_rev |-> ##[1:64] std_close)
        else $error("no close after standard reply to legacy peer");
    a_std_answers_req: assert property (
        leg_frm_vld && !leg_frm_rep |-> ##[1:64] (std_frm_vld && std_frm_rep))
        else $error("request left without reply");
    a_leg_answers_req: assert property (
        std_frm_vld && !std_frm_rep |-> ##[1:64] (leg_frm_vld && leg_frm_rep))
        else $error("legacy peer did not reply");
endmodule

// *** framing_link_param_negotiator_tb_top.sv ***
`timescale 1ns/1ps
// ********************************************************
// Bench: standard end against legacy peer, four pairings
// ********************************************************
module framing_link_param_negotiator_tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic rdma, closed, ver, m_init, m_resp, crc_en, ulp_leg;
    logic leg_start = 1'b0;
    logic leg_rdma, leg_closed;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    // Last frame seen from each end, as {rep, rev, m, c}
    logic [3:0] std_frm = 4'h0;
    logic [3:0] leg_frm = 4'h0;

    flpn_link_if link ();
    flpn_std_end i_flpn_std_end (.clk_sys_in(clk), .srst_in(srst), .link(link), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
        .rdma_mode_out(rdma), .closed_out(closed), .ver_out(ver), .mrk_init_rx_out(m_init),
        .mrk_resp_rx_out(m_resp), .crc_en_out(crc_en), .ulp_legacy_out(ulp_leg));
    flpn_leg_end i_flpn_leg_end (.clk_sys_in(clk), .srst_in(srst), .link(link), .start_in(leg_start),
        .rdma_mode_out(leg_rdma), .closed_out(leg_closed));
    flpn_link_checker i_flpn_link_checker (.clk_sys_in(clk), .srst_in(srst),
        .std_frm_vld(link.std_frm_vld), .std_frm_rep(link.std_frm_rep), .std_frm_rev(link.std_frm_rev),
        .std_frm_m(link.std_frm_m), .std_frm_c(link.std_frm_c), .std_close(link.std_close),
        .leg_frm_vld(link.leg_frm_vld), .leg_frm_rep(link.leg_frm_rep), .leg_frm_rev(link.leg_frm_rev),
        .leg_frm_m(link.leg_frm_m), .leg_frm_c(link.leg_frm_c), .leg_close(link.leg_close));

    // 50 MHz clock
    always #10 clk = ~clk;

    // Hang guard, far above four exchanges with polling
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            complete_run();
        end
    end

    // Frame monitor on the wire itself; reset clears it so no case sees a stale frame
    always @(posedge clk) begin
        if (srst) begin
            std_frm <= 4'h0;
            leg_frm <= 4'h0;
        end else begin
            if (link.std_frm_vld === 1'b1) begin
                std_frm <= {link.std_frm_rep, link.std_frm_rev, link.std_frm_m, link.std_frm_c};
            end
            if (link.leg_frm_vld === 1'b1) begin
                leg_frm <= {link.leg_frm_rep, link.leg_frm_rev, link.leg_frm_m, link.leg_frm_c};
            end
        end
    end

    // ********************************************************
    // Shared tasks
    // ********************************************************
    task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [3:0] addr, input logic [31:0] data);
        @(posedge clk);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand from the cycle after the strobe until the next read
    task automatic reg_read(input logic [3:0] addr, output logic [31:0] data);
        @(posedge clk);
        reg_addr <= addr;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        data = reg_rdata;
    endtask

    task automatic complete_run();
        if (fails == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One full connection: reset, configure, exchange, judge
    task automatic run_case(input logic leg_init, input logic perm);
        logic [31:0] ctrl;
        logic [31:0] st;
        int n;
        @(posedge clk);
        srst <= 1'b1;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        reg_read(flpn_pkg::OFS_CTRL, st);
        check("ctrl perm rst", 4'(st[flpn_pkg::CTRL_PERMISSIVE_BIT]), 4'(flpn_pkg::RST_PERMISSIVE));
        check("ctrl m rst", 4'(st[flpn_pkg::CTRL_PREF_M_BIT]), 4'(flpn_pkg::RST_PREF_M));
        check("ctrl c rst", 4'(st[flpn_pkg::CTRL_PREF_C_BIT]), 4'(flpn_pkg::RST_PREF_C));
        reg_read(4'h8, st);
        check("unmapped", st[3:0], 4'h0);
        check("rdma before", 4'(rdma), 4'h0);
        // Markers and checksum off locally; in permissive mode a legacy peer must still force them on
        ctrl = 32'h0;
        ctrl[flpn_pkg::CTRL_PERMISSIVE_BIT] = perm;
        ctrl[flpn_pkg::CTRL_START_BIT] = !leg_init;
        reg_write(flpn_pkg::OFS_CTRL, ctrl);
        if (leg_init) begin
            @(posedge clk);
            leg_start <= 1'b1;
            @(posedge clk);
            leg_start <= 1'b0;
        end
        st = 32'h0;
        n = 0;
        while (st[flpn_pkg::STAT_RDMA_BIT] !== 1'b1 && st[flpn_pkg::STAT_CLOSED_BIT] !== 1'b1 && n < 300) begin
            reg_read(flpn_pkg::OFS_STATUS, st);
            n++;
        end
        // Let a graceful close run to its end
        repeat (20) @(posedge clk);
        reg_read(flpn_pkg::OFS_STATUS, st);
        check("rdma bit", 4'(st[flpn_pkg::STAT_RDMA_BIT]), 4'(perm));
        check("closed bit", 4'(st[flpn_pkg::STAT_CLOSED_BIT]), 4'(!perm));
        check("ver bit", 4'(st[flpn_pkg::STAT_VER_BIT]), 4'(perm ? flpn_pkg::VER_LEGACY : flpn_pkg::VER_STD));
        check("leg rdma", 4'(leg_rdma), 4'(perm));
        check("closed out", 4'(closed), 4'(!perm));
        check("leg closed", 4'(leg_closed), 4'(!perm));
        if (perm) begin
            check("state", st[3:0], {1'b0, flpn_pkg::ST_RDMA});
            check("status m c leg", st[10:7], 4'hf);
            check("ver out", 4'(ver), 4'(flpn_pkg::VER_LEGACY));
            check("marks out", {2'h0, m_init, m_resp}, 4'h3);
            check("crc out", 4'(crc_en), 4'h1);
            check("ulp out", 4'(ulp_leg), 4'h1);
            check("rdma out", 4'(rdma), 4'h1);
        end
        if (leg_init) begin
            check("leg req", leg_frm, 4'h3);
            check("std rep rev", std_frm[3:2], perm ? 4'h2 : 4'h3);
            check("std rep mc", std_frm[1:0], perm ? 4'h3 : {2'h0, flpn_pkg::PREF_OFF, flpn_pkg::PREF_OFF});
        end else begin
            check("std req rev", std_frm[3:2], 4'h1);
            check("leg rep", leg_frm[3:1], 4'h5);
        end
    endtask

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        run_case(1'b0, 1'b1);
        run_case(1'b0, 1'b0);
        run_case(1'b1, 1'b1);
        run_case(1'b1, 1'b0);
        complete_run();
    end
endmodule
